//--- design/btag_pkg.sv
// Package for the block transfer address generator: field layout, modes, stack aliases
package btag_pkg;
    localparam int unsigned OPC_HI     = 27;
    localparam int unsigned OPC_LO     = 25;
    localparam logic [2:0]  OPC_BLOCK  = 3'h4;
    localparam int unsigned BIT_PRE    = 24;
    localparam int unsigned BIT_UP     = 23;
    localparam int unsigned BIT_USER   = 22;
    localparam int unsigned BIT_WB     = 21;
    localparam int unsigned BIT_LOAD   = 20;
    localparam int unsigned BASE_HI    = 19;
    localparam int unsigned BASE_LO    = 16;
    localparam int unsigned LIST_W     = 16;
    localparam int unsigned PC_INDEX   = 15;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;

    typedef enum logic [1:0] {
        BTAG_DECREMENT_AFTER  = 2'h0,
        BTAG_INCREMENT_AFTER  = 2'h1,
        BTAG_DECREMENT_BEFORE = 2'h2,
        BTAG_INCREMENT_BEFORE = 2'h3
    } btag_mode_t;

    typedef enum logic [1:0] {
        BTAG_FULL_DESCENDING_STACK  = 2'h0,
        BTAG_EMPTY_DESCENDING_STACK = 2'h1,
        BTAG_FULL_ASCENDING_STACK   = 2'h2,
        BTAG_EMPTY_ASCENDING_STACK  = 2'h3
    } btag_stack_t;

    typedef enum logic [1:0] {
        BTAG_IDLE  = 2'h0,
        BTAG_XFER  = 2'h1,
        BTAG_WBACK = 2'h2
    } btag_state_t;
endpackage

//--- design/btag_block_transfer_address_gen.sv
// Block load/store-multiple address generator: decode, address walk, writeback
`timescale 1ns/1ps
module btag_block_transfer_address_gen
    import btag_pkg::*;
#(
    parameter int unsigned ADDR_W = 32
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire logic [31:0]       instr_word,
    input  wire logic              cond_pass,
    input  wire logic              privileged_mode,
    input  wire logic [ADDR_W-1:0] base_value,
    input  wire logic              mem_ready,
    output logic                   busy,
    output logic                   instr_accept,
    output logic                   not_block_transfer,
    output logic [1:0]             stack_type,
    output logic [ADDR_W-1:0]      start_address,
    output logic [ADDR_W-1:0]      end_address,
    output logic                   mem_valid,
    output logic [ADDR_W-1:0]      mem_address,
    output logic [3:0]             mem_reg_index,
    output logic                   mem_is_load,
    output logic                   mem_user_bank,
    output logic                   wb_valid,
    output logic [3:0]             wb_reg,
    output logic [ADDR_W-1:0]      wb_value,
    output logic                   status_restore,
    output logic                   xfer_done
);

    btag_state_t             state_r, state_nxt;
    logic [LIST_W-1:0]       list_r;
    logic [ADDR_W-1:0]       addr_r;
    logic [ADDR_W-1:0]       start_r, end_r, wbv_r;
    logic [3:0]              base_r, idx_r;
    logic                    load_r, user_r, wb_r, restore_r, nbt_r;
    logic [1:0]              stack_r;
    btag_mode_t              mode_r;

    // Field decode of the incoming word
    wire logic        d_block = instr_word[OPC_HI:OPC_LO] == OPC_BLOCK;
    wire logic        d_pre   = instr_word[BIT_PRE];
    wire logic        d_up    = instr_word[BIT_UP];
    wire logic        d_user  = instr_word[BIT_USER];
    wire logic        d_wb    = instr_word[BIT_WB];
    wire logic        d_load  = instr_word[BIT_LOAD];
    wire logic [3:0]  d_base  = instr_word[BASE_HI:BASE_LO];
    wire logic [LIST_W-1:0] d_list = instr_word[LIST_W-1:0];
    wire btag_mode_t  d_mode  = btag_mode_t'({d_pre, d_up});

    // Five bits, since all sixteen list bits may be set
    logic [4:0] d_count;
    always_comb begin
        d_count = 5'h00;
        for (int i = 0; i < LIST_W; i++) begin
            d_count = d_count + {4'h0, d_list[i]};
        end
    end

    wire logic [ADDR_W-1:0] d_span = ADDR_W'({d_count, 2'h0});

    // Mode selects start and end of the range; the walk always climbs
    wire logic [ADDR_W-1:0] d_start =
        (d_mode == BTAG_INCREMENT_AFTER)  ? base_value :
        (d_mode == BTAG_INCREMENT_BEFORE) ? base_value + WORD_STEP[ADDR_W-1:0] :
        (d_mode == BTAG_DECREMENT_AFTER)  ?
            base_value - d_span + WORD_STEP[ADDR_W-1:0] :
            base_value - d_span;
    wire logic [ADDR_W-1:0] d_end = d_start + d_span - WORD_STEP[ADDR_W-1:0];
    wire logic [ADDR_W-1:0] d_wbv = d_up ? base_value + d_span
                                         : base_value - d_span;

    // Stack alias implied by load flag and mode: loads pop, stores push
    wire logic [1:0] d_stack =
        (d_mode == BTAG_INCREMENT_AFTER)  ? (d_load ? BTAG_FULL_DESCENDING_STACK
                                                    : BTAG_EMPTY_ASCENDING_STACK) :
        (d_mode == BTAG_INCREMENT_BEFORE) ? (d_load ? BTAG_EMPTY_DESCENDING_STACK
                                                    : BTAG_FULL_ASCENDING_STACK) :
        (d_mode == BTAG_DECREMENT_AFTER)  ? (d_load ? BTAG_FULL_ASCENDING_STACK
                                                    : BTAG_EMPTY_DESCENDING_STACK) :
                                            (d_load ? BTAG_EMPTY_ASCENDING_STACK
                                                    : BTAG_FULL_DESCENDING_STACK);

    // Lowest remaining selected register
    // Scanning downward lets the lowest set bit make the last assignment
    logic [3:0] low_idx;
    always_comb begin
        low_idx = 4'h0;
        for (int i = LIST_W - 1; i >= 0; i--) begin
            if (list_r[i]) begin
                low_idx = 4'(i);
            end
        end
    end

    wire logic d_has_pc  = d_list[PC_INDEX];
    // Nothing counts as taken while reset is held
    wire logic take      = (state_r == BTAG_IDLE) && instr_valid && !rst;
    // An empty list is refused at start and walks zero words
    wire logic start_go  = take && d_block && cond_pass && (d_list != '0);
    wire logic step      = (state_r == BTAG_XFER) && mem_ready;
    wire logic [LIST_W-1:0] list_left = list_r & ~(LIST_W'(1) << low_idx);
    wire logic last_step = step && (list_left == '0);

    // Handshake outputs decode the state; data outputs come from registers
    assign instr_accept       = take;
    assign busy               = state_r != BTAG_IDLE;
    assign mem_valid          = state_r == BTAG_XFER;
    assign mem_address        = addr_r;
    assign mem_reg_index      = low_idx;
    assign mem_is_load        = load_r;
    assign mem_user_bank      = user_r;
    assign start_address      = start_r;
    assign end_address        = end_r;
    assign stack_type         = stack_r;
    assign not_block_transfer = nbt_r;
    assign wb_reg             = base_r;
    assign wb_value           = wbv_r;
    assign wb_valid           = (state_r == BTAG_WBACK) && wb_r;
    assign status_restore     = (state_r == BTAG_WBACK) && restore_r;
    assign xfer_done          = state_r == BTAG_WBACK;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BTAG_IDLE: begin
                if (start_go) begin
                    state_nxt = BTAG_XFER;
                end
            end
            BTAG_XFER: begin
                if (last_step) begin
                    state_nxt = BTAG_WBACK;
                end
            end
            default: begin
                state_nxt = BTAG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= BTAG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture on start; address steps by four per accepted access
    always_ff @(posedge clk) begin
        if (rst) begin
            list_r    <= '0;
            addr_r    <= '0;
            start_r   <= '0;
            end_r     <= '0;
            wbv_r     <= '0;
            base_r    <= 4'h0;
            load_r    <= 1'b0;
            user_r    <= 1'b0;
            wb_r      <= 1'b0;
            restore_r <= 1'b0;
            stack_r   <= 2'h0;
            mode_r    <= BTAG_DECREMENT_AFTER;
            nbt_r     <= 1'b0;
        end else if (start_go) begin
            list_r    <= d_list;
            addr_r    <= d_start;
            start_r   <= d_start;
            end_r     <= d_end;
            wbv_r     <= d_wbv;
            base_r    <= d_base;
            load_r    <= d_load;
            // A program counter load with the user flag restores status instead
            user_r    <= d_user && privileged_mode && !(d_load && d_has_pc);
            wb_r      <= d_wb;
            restore_r <= d_user && d_load && d_has_pc;
            stack_r   <= d_stack;
            mode_r    <= d_mode;
            nbt_r     <= 1'b0;
        end else begin
            if (take) begin
                nbt_r <= !d_block;
            end
            if (step) begin
                list_r <= list_left;
                addr_r <= addr_r + WORD_STEP[ADDR_W-1:0];
            end
        end
    end

    // Helper: accesses issued in the current walk
    logic [4:0] issued_r;
    always_ff @(posedge clk) begin
        if (rst || start_go) begin
            issued_r <= 5'h00;
        end else if (step) begin
            issued_r <= issued_r + 5'h01;
        end
    end

    // Checks watch the walk through the ports and the captured state
    property p_first_addr;
        @(posedge clk) disable iff (rst) start_go |=> mem_address == $past(d_start);
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first address wrong");

    property p_step_four;
        @(posedge clk) disable iff (rst)
            step && !last_step |=> mem_address == $past(mem_address) + WORD_STEP[ADDR_W-1:0];
    endproperty
    a_step_four: assert property (p_step_four) else $error("address step not four");

    property p_last_is_end;
        @(posedge clk) disable iff (rst) last_step |-> mem_address == end_address;
    endproperty
    a_last_is_end: assert property (p_last_is_end) else $error("last address not end");

    // Writeback sits a fixed step from the range ends, set by the mode
    property p_wb_span;
        @(posedge clk) disable iff (rst)
            wb_valid |-> wb_value ==
                ((mode_r == BTAG_INCREMENT_AFTER)  ? end_address + WORD_STEP[ADDR_W-1:0] :
                 (mode_r == BTAG_INCREMENT_BEFORE) ? end_address :
                 (mode_r == BTAG_DECREMENT_AFTER)  ? start_address - WORD_STEP[ADDR_W-1:0] :
                                                     start_address);
    endproperty
    a_wb_span: assert property (p_wb_span) else $error("writeback value off range");

    property p_order;
        @(posedge clk) disable iff (rst)
            step && !last_step |=> mem_reg_index > $past(mem_reg_index);
    endproperty
    a_order: assert property (p_order) else $error("register order not rising");

    property p_count;
        @(posedge clk) disable iff (rst)
            last_step |-> end_address - start_address == ADDR_W'({issued_r, 2'h0});
    endproperty
    a_count: assert property (p_count) else $error("access count wrong");

    property p_restore_load;
        @(posedge clk) disable iff (rst) status_restore |-> mem_is_load && !mem_user_bank;
    endproperty
    a_restore_load: assert property (p_restore_load) else $error("restore on non load");

    property p_done_once;
        @(posedge clk) disable iff (rst) xfer_done |=> !xfer_done && !mem_valid;
    endproperty
    a_done_once: assert property (p_done_once) else $error("done not single pulse");

    property p_refused;
        @(posedge clk) disable iff (rst) take && !start_go |=> !busy;
    endproperty
    a_refused: assert property (p_refused) else $error("refused word started");

    // A stalled access must not move under the memory port
    property p_stall_hold;
        @(posedge clk) disable iff (rst)
            mem_valid && !mem_ready |=> mem_valid && $stable(mem_address)
                                        && $stable(mem_reg_index);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stalled access moved");

    property p_idx_in_list;
        @(posedge clk) disable iff (rst) mem_valid |-> list_r[mem_reg_index];
    endproperty
    a_idx_in_list: assert property (p_idx_in_list) else $error("index not in list");

    property p_ia_start;
        @(posedge clk) disable iff (rst)
            start_go && d_mode == BTAG_INCREMENT_AFTER
            |=> start_address == $past(base_value);
    endproperty
    a_ia_start: assert property (p_ia_start) else $error("start not base");

    property p_ib_start;
        @(posedge clk) disable iff (rst)
            start_go && d_mode == BTAG_INCREMENT_BEFORE
            |=> start_address == $past(base_value) + WORD_STEP[ADDR_W-1:0];
    endproperty
    a_ib_start: assert property (p_ib_start) else $error("start not base plus four");

    property p_da_end;
        @(posedge clk) disable iff (rst)
            start_go && d_mode == BTAG_DECREMENT_AFTER
            |=> end_address == $past(base_value);
    endproperty
    a_da_end: assert property (p_da_end) else $error("end not base");

    property p_db_end;
        @(posedge clk) disable iff (rst)
            start_go && d_mode == BTAG_DECREMENT_BEFORE
            |=> end_address == $past(base_value) - WORD_STEP[ADDR_W-1:0];
    endproperty
    a_db_end: assert property (p_db_end) else $error("end not base minus four");

    property p_nbt_set;
        @(posedge clk) disable iff (rst) take && !d_block |=> not_block_transfer;
    endproperty
    a_nbt_set: assert property (p_nbt_set) else $error("foreign opcode not flagged");

    // Pop from and push onto a full descending stack use opposite modes
    property p_fd_stack;
        @(posedge clk) disable iff (rst)
            start_go && (d_load ? (!d_pre && d_up) : (d_pre && !d_up))
            |=> stack_type == BTAG_FULL_DESCENDING_STACK;
    endproperty
    a_fd_stack: assert property (p_fd_stack) else $error("full descending alias wrong");

    property p_done_after;
        @(posedge clk) disable iff (rst) last_step |=> xfer_done;
    endproperty
    a_done_after: assert property (p_done_after) else $error("no done after last");

    c_wb: cover property (@(posedge clk) disable iff (rst) wb_valid);
    c_restore: cover property (@(posedge clk) disable iff (rst) status_restore);
    c_stall: cover property (@(posedge clk) disable iff (rst) mem_valid && !mem_ready);
    c_nbt: cover property (@(posedge clk) disable iff (rst) not_block_transfer);
    c_pc_load: cover property (@(posedge clk) disable iff (rst)
        mem_valid && mem_is_load && mem_reg_index == 4'(PC_INDEX));

endmodule

//--- verification/btag_mem_model.sv
// Memory port model: takes each access after one wait cycle, or after three when slow
`timescale 1ns/1ps
module btag_mem_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic mem_valid,
    output logic      mem_ready
);
    logic [1:0] wait_r;

    // Ready is a single-cycle pulse so every access is taken exactly once
    always_ff @(posedge clk) begin
        if (rst || !mem_valid || mem_ready) begin
            wait_r    <= 2'h0;
            mem_ready <= 1'b0;
        end else begin
            wait_r    <= wait_r + 2'h1;
            mem_ready <= !slow || wait_r == 2'h2;
        end
    end
endmodule

//--- verification/tb.sv
// Self-checking bench for the block transfer address generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    typedef struct packed {
        logic [31:0] w, b; logic c, p; logic [31:0] s, e, v; logic [1:0] k;
    } btag_row_t;
    logic        clk = 0, rst = 1, instr_valid = 0, cond_pass = 0, privileged_mode = 0, slow = 0;
    logic [31:0] instr_word = 0, base_value = 0, start_address, end_address, mem_address, wb_value;
    logic        busy, instr_accept, not_block_transfer, mem_valid, mem_ready, mem_is_load;
    logic        mem_user_bank, wb_valid, status_restore, xfer_done;
    logic [1:0]  stack_type;
    logic [3:0]  mem_reg_index, wb_reg;
    int          n_fail = 0, total_checks = 0, cyc = 0;
    btag_row_t   rows[10];

    always #2.5 clk = ~clk;

    btag_block_transfer_address_gen DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .cond_pass(cond_pass), .privileged_mode(privileged_mode),
        .base_value(base_value), .mem_ready(mem_ready), .busy(busy), .instr_accept(instr_accept),
        .not_block_transfer(not_block_transfer), .stack_type(stack_type),
        .start_address(start_address), .end_address(end_address), .mem_valid(mem_valid),
        .mem_address(mem_address), .mem_reg_index(mem_reg_index), .mem_is_load(mem_is_load),
        .mem_user_bank(mem_user_bank), .wb_valid(wb_valid), .wb_reg(wb_reg),
        .wb_value(wb_value), .status_restore(status_restore), .xfer_done(xfer_done));
    btag_mem_model u_mem (.clk(clk), .rst(rst), .slow(slow), .mem_valid(mem_valid),
        .mem_ready(mem_ready));

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Valid is held through the walk so that refusal while busy is exercised too
    task automatic run(input btag_row_t r);
        int i, ix, nacc;
        logic [31:0] a;
        logic dn, ok;
        a = r.s; ix = 0; nacc = 0; dn = 0;
        ok = r.c && r.w[27:25] == 3'h4;
        @(posedge clk);
        instr_word <= r.w; base_value <= r.b; cond_pass <= r.c; privileged_mode <= r.p;
        instr_valid <= 1'b1;
        @(posedge clk);
        `CHK("take", 1'b1, instr_accept)
        for (i = 0; i < (ok ? 90 : 6) && !dn; i++) begin
            @(posedge clk);
            if (busy === 1'b1) `CHK("accept", 1'b0, instr_accept)
            if (!ok) `CHK("walk", 1'b0, mem_valid)
            if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
                while (ix < 15 && r.w[ix] !== 1'b1) ix++;
                `CHK("addr", a, mem_address)
                `CHK("index", 4'(ix), mem_reg_index)
                `CHK("load", r.w[20], mem_is_load)
                `CHK("user", r.w[22] & r.p & ~(r.w[20] & r.w[15]), mem_user_bank)
                a += 4; ix++; nacc++;
            end
            if (xfer_done === 1'b1) begin
                dn = 1;
                `CHK("wb", r.w[21], wb_valid)
                if (r.w[21]) `CHK("wbval", r.v, wb_value)
                `CHK("wbreg", r.w[19:16], wb_reg)
                `CHK("restore", r.w[22] & r.w[20] & r.w[15], status_restore)
                `CHK("start", r.s, start_address)
                `CHK("end", r.e, end_address)
                `CHK("stack", r.k, stack_type)
            end
        end
        instr_valid <= 1'b0;
        `CHK("done", ok, dn)
        `CHK("count", ok ? $countones(r.w[15:0]) : 0, nacc)
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        // Every list is nonempty: an empty list is refused and never starts a walk
        rows = '{
            '{32'hE8FD8001, 32'h1000, 1'b1, 1'b1, 32'h1000, 32'h1004, 32'h1008, 2'h0},
            '{32'hE9E100F0, 32'h2000, 1'b1, 1'b1, 32'h2004, 32'h2010, 32'h2010, 2'h2},
            '{32'hE8100007, 32'h3000, 1'b1, 1'b0, 32'h2FF8, 32'h3000, 32'h0, 2'h2},
            '{32'hE922FFFF, 32'h8000, 1'b1, 1'b0, 32'h7FC0, 32'h7FFC, 32'h7FC0, 2'h0},
            '{32'hE9934000, 32'h0100, 1'b1, 1'b0, 32'h0104, 32'h0104, 32'h0, 2'h1},
            '{32'hE8A40101, 32'h0010, 1'b1, 1'b0, 32'h0010, 32'h0014, 32'h0018, 2'h3},
            '{32'hE9750006, 32'h0500, 1'b1, 1'b1, 32'h04F8, 32'h04FC, 32'h04F8, 2'h3},
            '{32'hE8268000, 32'h0600, 1'b1, 1'b1, 32'h0600, 32'h0600, 32'h05FC, 2'h1},
            '{32'hE8FD8001, 32'h1000, 1'b0, 1'b0, 32'h0, 32'h0, 32'h0, 2'h0},
            '{32'hE8C00003, 32'h0020, 1'b1, 1'b0, 32'h0020, 32'h0024, 32'h0, 2'h3}};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("busy", 1'b0, busy)
        `CHK("mvalid", 1'b0, mem_valid)
        `CHK("rstart", 32'h0, start_address)
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            slow <= i[0];
            run(rows[i]);
            $display("row %0d done", i);
        end
        // Reset in mid-walk must drop the walk; the next run proves a clean restart
        @(posedge clk);
        instr_word <= rows[3].w;
        base_value <= rows[3].b;
        cond_pass <= 1'b1;
        instr_valid <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("midbusy", 1'b1, busy)
        rst <= 1'b1;
        instr_valid <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("rbusy", 1'b0, busy)
        `CHK("rvalid", 1'b0, mem_valid)
        $display("mid-run reset test done");
        run('{32'hEA000001, 32'h0, 1'b1, 1'b0, 32'h0, 32'h0, 32'h0, 2'h0});
        `CHK("nbt", 1'b1, not_block_transfer)
        run(rows[5]);
        `CHK("nbt", 1'b0, not_block_transfer)
        $display("opcode test done");
        results();
    end
endmodule
